// ### sdwt_pkg.sv
// Shared constants for the write turnaround timing block: register map, field positions,
// reset values, burst encodings and burst timing terms.
// Assumes a 32-bit APB register bus and one command clock for everything.
`default_nettype none
package sdwt_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LAT  = 8'h04;
  localparam logic [7:0] OFS_TWR  = 8'h08;
  localparam logic [7:0] OFS_TWTR = 8'h0c;
  localparam logic [7:0] OFS_TRAS = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  // Field positions.
  localparam int unsigned CTRL_BL_LSB  = 0;
  localparam int unsigned CTRL_DBI_BIT = 2;
  localparam int unsigned CTRL_DM_BIT  = 3;
  localparam int unsigned LAT_AL_LSB   = 0;
  localparam int unsigned LAT_CWL_LSB  = 8;
  localparam int unsigned TWR_PL_LSB   = 0;
  localparam int unsigned TWR_DBI_LSB  = 8;
  localparam int unsigned TWTR_S_LSB   = 0;
  localparam int unsigned TWTR_L_LSB   = 8;
  localparam int unsigned STAT_PRE_BIT = 0;
  localparam int unsigned STAT_RD_BIT  = 1;
  localparam int unsigned STAT_RAS_BIT = 2;
  localparam int unsigned STAT_CFG_BIT = 3;
  localparam int unsigned STAT_BSY_BIT = 4;
  localparam int unsigned STAT_OPEN_LSB = 16;
  // Reset values.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LAT_RST  = 32'h0000_0900;
  localparam logic [31:0] TWR_RST  = 32'h0000_0e0c;
  localparam logic [31:0] TWTR_RST = 32'h0000_0602;
  localparam logic [31:0] TRAS_RST = 32'h0000_0020;
  // Burst-length field encodings.
  localparam logic [1:0] BL_FIXED8 = 2'b00;
  localparam logic [1:0] BL_OTF    = 2'b01;
  localparam logic [1:0] BL_CHOP4  = 2'b10;
  // Burst terms in clocks: command-to-recovery term and data window length.
  localparam logic [7:0] TERM_FULL = 8'h04;
  localparam logic [7:0] TERM_CHOP = 8'h02;
  localparam logic [2:0] DATA_BL8  = 3'h4;
  localparam logic [2:0] DATA_BC4  = 3'h2;
  localparam int unsigned NBANK = 16;
endpackage
`default_nettype wire

// ### sdwt_cmd_delay.sv
// Delay line for write command records with two programmable taps.
// Assumes tap values stay below DEPTH; tap 0 returns the input of the same cycle.
`default_nettype none
module sdwt_cmd_delay #(
  parameter int unsigned W     = 7,
  parameter int unsigned DEPTH = 132,
  parameter int unsigned TW    = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [W-1:0]  din,
  input  wire logic [TW-1:0] tap_a,
  input  wire logic [TW-1:0] tap_b,
  output logic      [W-1:0]  out_a,
  output logic      [W-1:0]  out_b
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] line;
  } sdwt_delay_t;
  sdwt_delay_t s;
  sdwt_delay_t next_s;

  // Stage k holds the record taken k+1 cycles ago.
  always_comb begin
    next_s.line = {s.line[DEPTH-2:0], din};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Tap reads; a zero tap bypasses the line so a write latency of one still works.
  assign out_a = (tap_a == '0) ? din : s.line[tap_a - 1'b1];
  assign out_b = (tap_b == '0) ? din : s.line[tap_b - 1'b1];
endmodule
`default_nettype wire

// ### sdwt_core.sv
// Write burst decode, write data window and write turnaround tracking for a DRAM.
// Assumes command pulses come from logic on pclk and an APB master configures the timing.
//
// Overview of operation
// - The fixed chop encoding in the burst field makes every write a four-beat burst.
// - With the on-the-fly encoding, A12 low chooses a four-beat chop and A12 high eight beats.
// - Eight beats come from the fixed eight-beat encoding or from on-the-fly with A12 high.
// - Write latency is additive latency plus CAS write latency, counted from the write.
// - Write recovery counts from the first rising edge after the last write data beat, or after the eight-beat end for an on-the-fly chop.
// - A write with A10 high precharges its bank itself after the burst; A10 low leaves it open.
// - Masking applies to writes only and is never active together with data inversion.
//
// The APB register port and the address map were decided locally.
`default_nettype none
module sdwt_core #(
  parameter int unsigned DEPTH = 132
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmd_act,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic        cmd_pre,
  input  wire logic [3:0]  cmd_bank,
  input  wire logic        cmd_a10,
  input  wire logic        cmd_a12,
  output logic             wdata_take,
  output logic             wdata_mask_en,
  output logic             wdata_inv_en,
  output logic [15:0]      bank_open,
  output logic             auto_pre,
  output logic [3:0]       auto_pre_bank
);
  import sdwt_pkg::*;

  typedef struct packed {
    logic [31:0]       ctrl;
    logic [31:0]       lat;
    logic [31:0]       twr;
    logic [31:0]       twtr;
    logic [31:0]       tras;
    logic [2:0]        sticky;
    logic [31:0]       rdata;
    logic [15:0]       open;
    logic [15:0]       pend;
    logic [15:0]       ap;
    logic [15:0][7:0]  rec;
    logic [15:0][7:0]  ras;
    logic [7:0]        wtr_s;
    logic [7:0]        wtr_l;
    logic [1:0]        last_bg;
    logic [2:0]        beats;
    logic [4:0]        inflight;
    logic              auto_pre;
    logic [3:0]        auto_bank;
  } sdwt_state_t;

  sdwt_state_t s;
  sdwt_state_t next_s;

  // Decide eight beats from the burst field and A12.
  function automatic logic burst_is_bl8(input logic [1:0] fld, input logic a12);
    burst_is_bl8 = (fld == BL_FIXED8) || ((fld == BL_OTF) && a12);
  endfunction

  // Address decode shared by read and write paths; returns 1 for a mapped offset.
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == OFS_CTRL) || (a == OFS_LAT) || (a == OFS_TWR) ||
                  (a == OFS_TWTR) || (a == OFS_TRAS) || (a == OFS_STAT);
  endfunction

  logic [1:0] fld;
  logic       dbi_en;
  logic       dm_en;
  logic [7:0] wl;
  logic [7:0] term;
  logic [7:0] tap_start;
  logic [7:0] tap_end;
  logic [6:0] entry;
  logic [6:0] rec_start;
  logic [6:0] rec_end;

  assign fld    = s.ctrl[CTRL_BL_LSB +: 2];
  assign dbi_en = s.ctrl[CTRL_DBI_BIT];
  assign dm_en  = s.ctrl[CTRL_DM_BIT];
  // Write latency sums the two latency fields.
  assign wl = {2'b00, s.lat[LAT_AL_LSB +: 6]} + {2'b00, s.lat[LAT_CWL_LSB +: 6]};
  // Fixed chop shortens the recovery start term; on-the-fly chop keeps the full term.
  assign term = (fld == BL_CHOP4) ? TERM_CHOP : TERM_FULL;
  // Taps land one cycle early so the loaded counters are live in the cycle itself.
  assign tap_start = (wl == 8'h00) ? 8'h00 : wl - 8'h01;
  assign tap_end   = wl + term - 8'h01;

  // Record: valid, eight beats, fixed chop, bank index.
  assign entry = {cmd_wr, burst_is_bl8(fld, cmd_a12), fld == BL_CHOP4, cmd_bank};

  sdwt_cmd_delay #(
    .W     (7),
    .DEPTH (DEPTH),
    .TW    (8)
  ) u_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (entry),
    .tap_a   (tap_start),
    .tap_b   (tap_end),
    .out_a   (rec_start),
    .out_b   (rec_end)
  );

  // Whole next-state computation: counters, bank bookkeeping, checks and APB.
  always_comb begin
    logic       found;
    logic       inc;
    logic       dec;
    logic       acc;
    logic       setup;
    logic [2:0] set_f;
    logic [2:0] clr_f;
    logic [3:0] eb;
    found = 1'b0;
    inc   = cmd_wr;
    dec   = rec_end[6];
    acc   = psel && penable;
    setup = psel && !penable;
    set_f = 3'b000;
    clr_f = 3'b000;
    eb    = rec_end[3:0];
    next_s = s;
    next_s.auto_pre = 1'b0;
    // Free-running down counters stop at zero.
    for (int i = 0; i < NBANK; i++) begin
      if (s.rec[i] != 8'h00) next_s.rec[i] = s.rec[i] - 8'h01;
      if (s.ras[i] != 8'h00) next_s.ras[i] = s.ras[i] - 8'h01;
    end
    if (s.wtr_s != 8'h00) next_s.wtr_s = s.wtr_s - 8'h01;
    if (s.wtr_l != 8'h00) next_s.wtr_l = s.wtr_l - 8'h01;
    if (s.beats != 3'h0) next_s.beats = s.beats - 3'h1;
    // Data window opens at write latency and spans four or two clocks.
    if (rec_start[6]) begin
      next_s.beats = rec_start[5] ? DATA_BL8 : DATA_BC4;
    end
    // Burst over: recovery and write-to-read timers start together.
    if (rec_end[6]) begin
      next_s.rec[eb] = dbi_en ? s.twr[TWR_DBI_LSB +: 8] : s.twr[TWR_PL_LSB +: 8];
      next_s.pend[eb] = 1'b0;
      next_s.wtr_s = s.twtr[TWTR_S_LSB +: 8];
      next_s.wtr_l = s.twtr[TWTR_L_LSB +: 8];
      next_s.last_bg = eb[3:2];
    end
    if (cmd_act) begin
      next_s.open[cmd_bank] = 1'b1;
      // One less than tRAS, so a precharge exactly tRAS clocks after the activate is legal.
      next_s.ras[cmd_bank] = (s.tras[7:0] == 8'h00) ? 8'h00 : s.tras[7:0] - 8'h01;
    end
    if (cmd_wr) begin
      next_s.pend[cmd_bank] = 1'b1;
      next_s.ap[cmd_bank] = cmd_a10;
    end
    // Early reads count against whichever write-to-read timer matches the group.
    if (cmd_rd) begin
      if (s.inflight != 5'h00) begin
        set_f[STAT_RD_BIT] = 1'b1;
      end else if (cmd_bank[3:2] == s.last_bg) begin
        if (s.wtr_l != 8'h00) set_f[STAT_RD_BIT] = 1'b1;
      end else begin
        if (s.wtr_s != 8'h00) set_f[STAT_RD_BIT] = 1'b1;
      end
    end
    if (cmd_pre) begin
      if (s.pend[cmd_bank] || s.rec[cmd_bank] != 8'h00) set_f[STAT_PRE_BIT] = 1'b1;
      if (s.ras[cmd_bank] != 8'h00) set_f[STAT_RAS_BIT] = 1'b1;
      next_s.open[cmd_bank] = 1'b0;
      next_s.ap[cmd_bank] = 1'b0;
    end
    // Internal precharge waits for recovery and tRAS; one bank closes per clock.
    for (int i = 0; i < NBANK; i++) begin
      if (!found && s.ap[i] && !s.pend[i] && s.rec[i] == 8'h00 && s.ras[i] == 8'h00) begin
        found = 1'b1;
        next_s.ap[i] = 1'b0;
        next_s.open[i] = 1'b0;
        next_s.auto_pre = 1'b1;
        next_s.auto_bank = 4'(i);
      end
    end
    next_s.inflight = s.inflight + 5'(inc) - 5'(dec);
    // Register writes take effect at the access edge.
    if (acc && pwrite) begin
      if (paddr == OFS_CTRL) begin
        next_s.ctrl = pwdata & 32'h0000_000f;
      end else if (paddr == OFS_LAT) begin
        next_s.lat = pwdata & 32'h0000_3f3f;
      end else if (paddr == OFS_TWR) begin
        next_s.twr = pwdata & 32'h0000_ffff;
      end else if (paddr == OFS_TWTR) begin
        next_s.twtr = pwdata & 32'h0000_ffff;
      end else if (paddr == OFS_TRAS) begin
        next_s.tras = pwdata & 32'h0000_00ff;
      end else if (paddr == OFS_STAT) begin
        clr_f = pwdata[2:0];
      end
    end
    // A violation in the clearing cycle survives the clear.
    next_s.sticky = (s.sticky & ~clr_f) | set_f;
    // Read data is fetched in the setup cycle so zero-wait access phases see it.
    if (setup && !pwrite) begin
      if (paddr == OFS_CTRL) begin
        next_s.rdata = s.ctrl;
      end else if (paddr == OFS_LAT) begin
        next_s.rdata = s.lat;
      end else if (paddr == OFS_TWR) begin
        next_s.rdata = s.twr;
      end else if (paddr == OFS_TWTR) begin
        next_s.rdata = s.twtr;
      end else if (paddr == OFS_TRAS) begin
        next_s.rdata = s.tras;
      end else if (paddr == OFS_STAT) begin
        next_s.rdata = {s.open, 11'h000, s.inflight != 5'h00, dm_en && dbi_en, s.sticky};
      end else begin
        next_s.rdata = 32'h0000_0000;
      end
    end
  end

  // All state registers on the one clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.lat <= LAT_RST;
      s.twr <= TWR_RST;
      s.twtr <= TWTR_RST;
      s.tras <= TRAS_RST;
    end else begin
      s <= next_s;
    end
  end

  assign prdata  = s.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign wdata_take = s.beats != 3'h0;
  // Mask and inversion share one pin per lane, so inversion takes the pin when both are set.
  assign wdata_mask_en = dm_en && !dbi_en;
  assign wdata_inv_en  = dbi_en;
  assign bank_open     = s.open;
  assign auto_pre      = s.auto_pre;
  assign auto_pre_bank = s.auto_bank;

  // Bank of the record leaving the line, kept for the recovery load checks.
  logic [3:0] eb_q;
  assign eb_q = rec_end[3:0];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fixed_chop: assert property (cmd_wr && fld == BL_CHOP4 |-> !entry[5])
    else $error("fixed chop write decoded as eight beats");
  a_otf_select: assert property (cmd_wr && fld == BL_OTF |-> entry[5] == cmd_a12)
    else $error("on-the-fly burst length not following A12");
  a_bl8_source: assert property (cmd_wr && entry[5] |-> fld == BL_FIXED8 || cmd_a12)
    else $error("eight beats selected without a legal source");
  a_data_window: assert property (rec_start[6] && rec_start[5] |=> wdata_take [*4])
    else $error("eight-beat data window shorter than four clocks");
  a_rec_load: assert property (rec_end[6] && !dbi_en |=> s.rec[$past(eb_q)] == s.twr[7:0])
    else $error("recovery not loaded with plain tWR");
  a_rec_dbi: assert property (rec_end[6] && dbi_en |=> s.rec[$past(eb_q)] == s.twr[15:8])
    else $error("recovery not loaded with tWR_DBI");
  a_pre_early: assert property (cmd_pre && s.rec[cmd_bank] != 8'h00 |=> s.sticky[0])
    else $error("early precharge not flagged");
  a_ras_early: assert property (cmd_pre && s.ras[cmd_bank] != 8'h00 |=> s.sticky[2])
    else $error("precharge inside tRAS not flagged");
  a_rd_same_bg: assert property (cmd_rd && s.inflight == 5'h00 &&
    cmd_bank[3:2] == s.last_bg && s.wtr_l != 8'h00 |=> s.sticky[1])
    else $error("early same-group read not flagged");
  a_rd_other_bg: assert property (cmd_rd && s.inflight == 5'h00 &&
    cmd_bank[3:2] != s.last_bg && s.wtr_s != 8'h00 |=> s.sticky[1])
    else $error("early other-group read not flagged");
  a_auto_close: assert property (auto_pre |->
    !bank_open[auto_pre_bank] && $past(s.ap) != 16'h0)
    else $error("auto precharge pulse without closing its bank");
  a_mask_dbi: assert property (wdata_inv_en |-> !wdata_mask_en)
    else $error("mask and inversion active together");
endmodule
`default_nettype wire

// ### sdwt_ctl_model.sv
// Controller-side command driver for the write turnaround block.
// Assumes the bench calls issue() from one process, synchronous to pclk.
`default_nettype none
module sdwt_ctl_model (
  output var logic       cmd_act,
  output var logic       cmd_wr,
  output var logic       cmd_rd,
  output var logic       cmd_pre,
  output var logic [3:0] cmd_bank,
  output var logic       cmd_a10,
  output var logic       cmd_a12,
  input  wire logic      pclk
);
  timeunit 1ns;
  timeprecision 1ps;

  // All command pins start idle.
  initial begin
    {cmd_act, cmd_wr, cmd_rd, cmd_pre, cmd_a10, cmd_a12} = 6'h00;
    cmd_bank = 4'h0;
  end

  // One pulse per call: 0 activate, 1 write, 2 read, 3 precharge.
  task automatic issue(input int k, input logic [3:0] b, input logic a10, input logic a12);
    @(posedge pclk);
    cmd_act <= (k == 0);
    cmd_wr <= (k == 1);
    cmd_rd <= (k == 2);
    cmd_pre <= (k == 3);
    cmd_bank <= b;
    cmd_a10 <= a10;
    cmd_a12 <= a12;
    @(posedge pclk);
    {cmd_act, cmd_wr, cmd_rd, cmd_pre} <= 4'h0;
    // Address pins flip once the command is gone, so a stale sample shows up.
    cmd_bank <= ~b;
    cmd_a10 <= ~a10;
    cmd_a12 <= ~a12;
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for sdwt_core: APB register access and command sequences.
// Assumes the controller model drives every command pin of the core.
`default_nettype none
module tb_top import sdwt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        cmd_act, cmd_wr, cmd_rd, cmd_pre, cmd_a10, cmd_a12;
  logic [3:0]  cmd_bank, auto_pre_bank, seen_bank;
  logic        wdata_take, wdata_mask_en, wdata_inv_en, auto_pre;
  logic [15:0] bank_open;
  int          mismatches, n_checks, first, cnt;

  // Short delay line: only needs to exceed AL + CWL + 3.
  sdwt_core #(.DEPTH(40)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd_act(cmd_act), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_pre(cmd_pre), .cmd_bank(cmd_bank), .cmd_a10(cmd_a10),
    .cmd_a12(cmd_a12), .wdata_take(wdata_take), .wdata_mask_en(wdata_mask_en),
    .wdata_inv_en(wdata_inv_en), .bank_open(bank_open), .auto_pre(auto_pre),
    .auto_pre_bank(auto_pre_bank));
  sdwt_ctl_model ctl (.cmd_act(cmd_act), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_pre(cmd_pre), .cmd_bank(cmd_bank), .cmd_a10(cmd_a10), .cmd_a12(cmd_a12),
    .pclk(pclk));

  // Free-running 125 MHz clock.
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Single comparison of a 32-bit result.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic gap(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (i == 16) begin
      mismatches++;
      summarize();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  // Measures where the write data window opens and how many clocks it lasts.
  task automatic burst(input logic [1:0] bl, input logic [31:0] lat, input logic a12,
                       input int wl, input int len);
    apb(1'h1, OFS_CTRL, {30'h0, bl});
    apb(1'h1, OFS_LAT, lat);
    ctl.issue(1, 4'h4, 1'h0, a12);
    first = 0;
    cnt = 0;
    for (int k = 1; k < 40; k++) begin
      #1;
      if (wdata_take === 1'h1) begin
        if (cnt == 0) first = k;
        cnt++;
      end
      @(posedge pclk);
    end
    chk("take_start", wl, first);
    chk("take_len", len, cnt);
  endtask

  // Activate, write, then a second command n clocks after the write; checks one status flag and the bank 0 open bit.
  task automatic space(input logic [31:0] ctrl, input int ag, input int k2,
                       input logic [3:0] b2, input int n, input int bi, input logic e);
    apb(1'h1, OFS_CTRL, ctrl);
    apb(1'h1, OFS_STAT, 32'h0000_0007);
    ctl.issue(0, 4'h0, 1'h0, 1'h1);
    gap(ag - 2);
    ctl.issue(1, 4'h0, 1'h0, 1'h1);
    gap(n - 2);
    ctl.issue(k2, b2, 1'h0, 1'h1);
    gap(4);
    apb(1'h0, OFS_STAT, 32'h0);
    chk("status_flag", {31'h0, e}, {31'h0, rd[bi]});
    chk("bank_open0", {31'h0, k2 != 3}, {31'h0, rd[STAT_OPEN_LSB]});
  endtask

  // Main sequence.
  initial begin
    logic [7:0]  ofs [5];
    logic [31:0] rv  [5];
    ofs = '{OFS_CTRL, OFS_LAT, OFS_TWR, OFS_TWTR, OFS_TRAS};
    rv = '{CTRL_RST, LAT_RST, TWR_RST, TWTR_RST, TRAS_RST};
    mismatches = 0;
    n_checks = 0;
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      apb(1'h0, ofs[i], 32'h0);
      chk("reset_value", rv[i], rd);
    end
    apb(1'h1, OFS_TRAS, 32'h0000_0021);
    apb(1'h0, OFS_TRAS, 32'h0);
    chk("tras_rw", 32'h0000_0021, rd);
    apb(1'h0, 8'h18, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    burst(BL_FIXED8, LAT_RST, 1'h0, 9, 4);
    burst(BL_OTF, LAT_RST, 1'h1, 9, 4);
    burst(BL_OTF, LAT_RST, 1'h0, 9, 2);
    burst(BL_CHOP4, LAT_RST, 1'h1, 9, 2);
    burst(BL_FIXED8, 32'h0000_0903, 1'h1, 12, 4);
    apb(1'h1, OFS_LAT, LAT_RST);
    space(32'h0, 12, 3, 4'h0, 24, 0, 1'h1);
    space(32'h0, 12, 3, 4'h0, 25, 0, 1'h0);
    space(32'h2, 12, 3, 4'h0, 22, 0, 1'h1);
    space(32'h2, 12, 3, 4'h0, 23, 0, 1'h0);
    space(32'h4, 12, 3, 4'h0, 26, 0, 1'h1);
    space(32'h4, 12, 3, 4'h0, 27, 0, 1'h0);
    space(32'h0, 12, 2, 4'h4, 14, 1, 1'h1);
    space(32'h0, 12, 2, 4'h4, 15, 1, 1'h0);
    space(32'h0, 12, 2, 4'h1, 18, 1, 1'h1);
    space(32'h0, 12, 2, 4'h1, 19, 1, 1'h0);
    space(32'h0, 2, 3, 4'h0, 25, 2, 1'h1);
    space(32'h0, 2, 3, 4'h0, 31, 2, 1'h0);
    // Auto precharge: bank 1 opens, then closes by itself after recovery.
    apb(1'h1, OFS_CTRL, 32'h0);
    ctl.issue(0, 4'h1, 1'h0, 1'h1);
    gap(10);
    #1;
    chk("bank_open1", 32'h1, {31'h0, bank_open[1]});
    ctl.issue(1, 4'h1, 1'h1, 1'h1);
    first = 0;
    seen_bank = 4'h0;
    for (int k = 1; k < 40; k++) begin
      #1;
      if (auto_pre === 1'h1 && first == 0) begin
        first = k;
        seen_bank = auto_pre_bank;
      end
      @(posedge pclk);
    end
    chk("auto_pre_at", 26, first);
    chk("auto_pre_bank", 32'h1, {28'h0, seen_bank});
    chk("bank_closed1", 32'h0, {31'h0, bank_open[1]});
    // Masking and inversion never both active.
    for (int m = 0; m < 4; m++) begin
      apb(1'h1, OFS_CTRL, {28'h0, m[1:0], 2'h0});
      #1;
      chk("mask_en", {31'h0, m[1] & ~m[0]}, {31'h0, wdata_mask_en});
      chk("inv_en", {31'h0, m[0]}, {31'h0, wdata_inv_en});
      apb(1'h0, OFS_STAT, 32'h0);
      chk("both_flag", {31'h0, m[1] & m[0]}, {31'h0, rd[3]});
    end
    summarize();
  end
endmodule
`default_nettype wire
